// ===== spbpe_defines.svh
// Functional notes
// - direct store bumps stack pointer, then copies target byte to new stack slot.
// - source ninth bit goes to status bit one and stacked bit eight only when mem_rbit8 is set; else stacked bit eight is 0.
// - page zero uses 64H, page one 65H, page FE 63H, others 66H three bytes.
// - direct store advances program counter by two short, three long.
// - long store takes any address, opcode 66H, low then high byte.
// - long store pre-increments, copies ninth bit, advances counter by three.
// - pair store: bump, write reg_a byte, bump again, write reg_b byte, counter plus one.
// - pair store writes status bit one into both stacked bit eights.
// - status store 80H: bump, store status word, counter plus one.
// - status store copies status bit one into stacked bit eight.
// - stack pointer is two byte registers at FE0AH and FE0BH.
`ifndef SPBPE_DEFINES_SVH
`define SPBPE_DEFINES_SVH
`define OP_DIR0    8'h64
`define OP_DIR1    8'h65
`define OP_DIRF    8'h63
`define OP_LONG    8'h66
`define OP_PAIR    8'h60
`define OP_PSW     8'h80
`define PAGE_0     8'h00
`define PAGE_1     8'h01
`define PAGE_F     8'hFE
`define STEP_0     2'h0
`define STEP_1     2'h1
`define STEP_2     2'h2
`define STEP_3     2'h3
`define ADR_SP_LO  16'hFE0A
`define ADR_SP_HI  16'hFE0B
`define ADR_PSW    16'hFE06
`define SP_RST     16'h0000
`define SP_INC     16'h0001
`define PSW_RST    8'h00
`define STAT_BIT1  1
`define NINTH_BIT  8
`endif

// ===== spbpe_pkg.sv
package spbpe_pkg;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_LONG  = 5'h02,
		ST_READ  = 5'h04,
		ST_STORE = 5'h08,
		ST_PAIR  = 5'h10
	} spbpe_state_t;
	typedef enum logic [1:0] {
		K_NONE = 2'h0,
		K_BYTE = 2'h1,
		K_PAIR = 2'h2,
		K_PSW  = 2'h3
	} spbpe_kind_t;
endpackage : spbpe_pkg

// ===== spbpe_dec_if.sv
`timescale 1ns/10ps
interface spbpe_dec_if;
	logic [7:0]               opcode;
	logic                     legal;
	logic                     long_form;
	spbpe_pkg::spbpe_kind_t   kind;
	logic [7:0]               page;
	logic [1:0]               pc_step;
	modport dec  (input opcode, output legal, long_form, kind, page, pc_step);
	modport core (output opcode, input legal, long_form, kind, page, pc_step);
endinterface : spbpe_dec_if

// ===== spbpe_decoder.sv
`timescale 1ns/10ps
`include "spbpe_defines.svh"
module spbpe_decoder (
	spbpe_dec_if.dec d
);
	always_comb begin
		d.legal = 1'b1;
		d.long_form = 1'b0;
		d.kind = spbpe_pkg::K_BYTE;
		d.page = `PAGE_0;
		d.pc_step = `STEP_2;
		case (d.opcode)
			`OP_DIR0: begin
				d.page = `PAGE_0;
			end
			`OP_DIR1: begin
				d.page = `PAGE_1;
			end
			`OP_DIRF: begin
				d.page = `PAGE_F;
			end
			`OP_LONG: begin
				d.long_form = 1'b1;
				d.pc_step = `STEP_3;
			end
			`OP_PAIR: begin
				d.kind = spbpe_pkg::K_PAIR;
				d.pc_step = `STEP_1;
			end
			`OP_PSW: begin
				d.kind = spbpe_pkg::K_PSW;
				d.pc_step = `STEP_1;
			end
			default: begin
				d.legal = 1'b0;
				d.kind = spbpe_pkg::K_NONE;
				d.pc_step = `STEP_0;
			end
		endcase
	end
endmodule : spbpe_decoder

// ===== spbpe_exec.sv
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "spbpe_defines.svh"
module spbpe_exec (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	input  wire logic [7:0]  instr_opcode,
	input  wire logic [7:0]  instr_lo,
	input  wire logic [7:0]  instr_hi,
	input  wire logic [7:0]  reg_a,
	input  wire logic [7:0]  reg_b,
	output logic             done,
	output logic [1:0]       pc_step,
	output logic             illegal,
	output logic             mem_rd,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [8:0]       mem_wdata,
	input  wire logic [8:0]  mem_rdata,
	input  wire logic        mem_rbit8,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	output logic [15:0]      sp,
	output logic [7:0]       program_status_word
);

////////////////////////////////////////////////////////////////////////////////

	spbpe_dec_if dif ();

	assign dif.opcode = instr_opcode;

	spbpe_decoder u_dec (
		.d (dif)
	);

////////////////////////////////////////////////////////////////////////////////

	spbpe_pkg::spbpe_state_t state_q;
	spbpe_pkg::spbpe_state_t state_d;
	spbpe_pkg::spbpe_kind_t  kind_q;
	spbpe_pkg::spbpe_kind_t  kind_d;
	logic [15:0]             sp_q;
	logic [15:0]             sp_d;
	logic [7:0]              psw_q;
	logic [7:0]              psw_d;
	logic [15:0]             tgt_q;
	logic [15:0]             tgt_d;
	logic [1:0]              step_q;
	logic [1:0]              step_d;
	logic                    mem_rd_q;
	logic                    mem_rd_d;
	logic                    mem_we_q;
	logic                    mem_we_d;
	logic [15:0]             mem_addr_q;
	logic [15:0]             mem_addr_d;
	logic [8:0]              mem_wdata_q;
	logic [8:0]              mem_wdata_d;
	logic                    done_q;
	logic                    done_d;
	logic [1:0]              pc_step_q;
	logic [1:0]              pc_step_d;
	logic                    ill_q;
	logic                    ill_d;
	logic [7:0]              rdata_q;
	logic [7:0]              rdata_d;
	logic                    acc;
	logic                    sp_free;
	logic [15:0]             sp_inc;

	assign acc = instr_valid && (state_q == spbpe_pkg::ST_IDLE);
	// bus writes to the pointer only land while no push is in flight
	assign sp_free = (state_q == spbpe_pkg::ST_IDLE) && !instr_valid;
	assign sp_inc = sp_q + `SP_INC;

////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		sp_d = sp_q;
		psw_d = psw_q;
		tgt_d = tgt_q;
		step_d = step_q;
		mem_rd_d = 1'b0;
		mem_we_d = 1'b0;
		mem_addr_d = mem_addr_q;
		mem_wdata_d = mem_wdata_q;
		done_d = 1'b0;
		pc_step_d = pc_step_q;
		ill_d = 1'b0;
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`ADR_SP_LO: rdata_d = sp_q[7:0];
				`ADR_SP_HI: rdata_d = sp_q[15:8];
				`ADR_PSW:   rdata_d = psw_q;
				default:    rdata_d = 8'h00;
			endcase
		end
		// software write first so a ninth-bit update below wins
		if (reg_wr) begin
			case (reg_addr)
				`ADR_SP_LO: begin
					if (sp_free) begin
						sp_d[7:0] = reg_wdata;
					end
				end
				`ADR_SP_HI: begin
					if (sp_free) begin
						sp_d[15:8] = reg_wdata;
					end
				end
				`ADR_PSW: psw_d = reg_wdata;
				default: ;
			endcase
		end
		case (state_q)
			spbpe_pkg::ST_IDLE: begin
				if (instr_valid) begin
					kind_d = dif.kind;
					step_d = dif.pc_step;
					if (!dif.legal) begin
						done_d = 1'b1;
						ill_d = 1'b1;
						pc_step_d = `STEP_0;
					end else begin
						sp_d = sp_inc;
						case (dif.kind)
							spbpe_pkg::K_BYTE: begin
								if (dif.long_form) begin
									tgt_d = {instr_hi, instr_lo};
									state_d = spbpe_pkg::ST_LONG;
								end else begin
									tgt_d = {dif.page, instr_lo};
									mem_rd_d = 1'b1;
									mem_addr_d = {dif.page, instr_lo};
									state_d = spbpe_pkg::ST_READ;
								end
							end
							spbpe_pkg::K_PAIR: begin
								tgt_d = {8'h00, reg_b};
								mem_we_d = 1'b1;
								mem_addr_d = sp_inc;
								mem_wdata_d = {psw_q[`STAT_BIT1], reg_a};
								state_d = spbpe_pkg::ST_PAIR;
							end
							spbpe_pkg::K_PSW: begin
								mem_we_d = 1'b1;
								mem_addr_d = sp_inc;
								mem_wdata_d = {psw_q[`STAT_BIT1], psw_q};
								done_d = 1'b1;
								pc_step_d = dif.pc_step;
							end
							default: ;
						endcase
					end
				end
			end
			spbpe_pkg::ST_LONG: begin
				// second machine cycle of the three-byte form
				mem_rd_d = 1'b1;
				mem_addr_d = tgt_q;
				state_d = spbpe_pkg::ST_READ;
			end
			spbpe_pkg::ST_READ: begin
				state_d = spbpe_pkg::ST_STORE;
			end
			spbpe_pkg::ST_STORE: begin
				mem_we_d = 1'b1;
				mem_addr_d = sp_q;
				mem_wdata_d = {mem_rbit8 & mem_rdata[`NINTH_BIT], mem_rdata[7:0]};
				if (mem_rbit8) begin
					psw_d[`STAT_BIT1] = mem_rdata[`NINTH_BIT];
				end
				done_d = 1'b1;
				pc_step_d = step_q;
				state_d = spbpe_pkg::ST_IDLE;
			end
			spbpe_pkg::ST_PAIR: begin
				sp_d = sp_inc;
				mem_we_d = 1'b1;
				mem_addr_d = sp_inc;
				mem_wdata_d = {psw_q[`STAT_BIT1], tgt_q[7:0]};
				done_d = 1'b1;
				pc_step_d = step_q;
				state_d = spbpe_pkg::ST_IDLE;
			end
			default: begin
				state_d = spbpe_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q <= spbpe_pkg::ST_IDLE;
			kind_q <= spbpe_pkg::K_NONE;
			sp_q <= `SP_RST;
			psw_q <= `PSW_RST;
			tgt_q <= 16'h0000;
			step_q <= `STEP_0;
			mem_rd_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 9'h000;
			done_q <= 1'b0;
			pc_step_q <= `STEP_0;
			ill_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			sp_q <= sp_d;
			psw_q <= psw_d;
			tgt_q <= tgt_d;
			step_q <= step_d;
			mem_rd_q <= mem_rd_d;
			mem_we_q <= mem_we_d;
			mem_addr_q <= mem_addr_d;
			mem_wdata_q <= mem_wdata_d;
			done_q <= done_d;
			pc_step_q <= pc_step_d;
			ill_q <= ill_d;
			rdata_q <= rdata_d;
		end
	end

	assign instr_ready = (state_q == spbpe_pkg::ST_IDLE);
	assign done = done_q;
	assign pc_step = pc_step_q;
	assign illegal = ill_q;
	assign mem_rd = mem_rd_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign reg_rdata = rdata_q;
	assign sp = sp_q;
	assign program_status_word = psw_q;

////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_sp_pre_inc: assert property (
		acc && dif.legal |=> sp_q == $past(sp_q) + `SP_INC
	) else $error("stack pointer not pre-incremented");

	a_short_timing: assert property (
		acc && dif.legal && dif.kind == spbpe_pkg::K_BYTE && !dif.long_form
		|=> mem_rd_q ##1 !mem_we_q ##1 mem_we_q && done_q && pc_step_q == `STEP_2
	) else $error("short direct store timing or step wrong");

	a_long_timing: assert property (
		acc && instr_opcode == `OP_LONG
		|=> !mem_rd_q ##1 mem_rd_q && mem_addr_q == $past(tgt_q)
		##2 mem_we_q && done_q && pc_step_q == `STEP_3
	) else $error("long store timing or step wrong");

	a_page_one_map: assert property (
		acc && instr_opcode == `OP_DIR1
		|=> mem_rd_q && mem_addr_q == {`PAGE_1, $past(instr_lo)}
	) else $error("page one target address wrong");

	a_store_at_sp: assert property (
		mem_we_q |-> mem_addr_q == sp_q
	) else $error("stack write not at stack pointer");

	a_ninth_copy: assert property (
		state_q == spbpe_pkg::ST_STORE && mem_rbit8
		|=> mem_wdata_q[`NINTH_BIT] == $past(mem_rdata[`NINTH_BIT])
		&& psw_q[`STAT_BIT1] == $past(mem_rdata[`NINTH_BIT])
	) else $error("ninth bit not propagated");

	a_pair_order: assert property (
		acc && instr_opcode == `OP_PAIR
		|=> mem_we_q && mem_wdata_q[7:0] == $past(reg_a)
		##1 mem_we_q && mem_wdata_q[7:0] == $past(reg_b, 2)
		&& sp_q == $past(sp_q, 2) + 16'h0002 && done_q && pc_step_q == `STEP_1
	) else $error("pair store order or pointer wrong");

	a_pair_bit8: assert property (
		acc && instr_opcode == `OP_PAIR
		|=> mem_wdata_q[`NINTH_BIT] == $past(psw_q[`STAT_BIT1])
		##1 mem_wdata_q[`NINTH_BIT] == $past(psw_q[`STAT_BIT1], 2)
	) else $error("pair bit eight not status bit one");

	a_psw_store: assert property (
		acc && instr_opcode == `OP_PSW
		|=> mem_we_q && mem_wdata_q == {$past(psw_q[`STAT_BIT1]), $past(psw_q)}
		&& done_q && pc_step_q == `STEP_1
	) else $error("status store data or step wrong");

	c_long: cover property (acc && instr_opcode == `OP_LONG ##4 done_q);
	c_pair: cover property (acc && instr_opcode == `OP_PAIR ##2 done_q);
	c_psw: cover property (acc && instr_opcode == `OP_PSW ##1 done_q);
	c_ninth: cover property (state_q == spbpe_pkg::ST_STORE && mem_rbit8);

endmodule : spbpe_exec

// ===== tb_spbpe_exec.sv
`timescale 1ns/10ps
module tb_spbpe_exec;
	logic        ref_clk      = 1'b0;
	logic        rst_b        = 1'b0;
	logic        instr_valid  = 1'b0;
	logic [7:0]  instr_opcode = 8'h00;
	logic [7:0]  instr_lo     = 8'h00;
	logic [7:0]  instr_hi     = 8'h00;
	logic [7:0]  reg_a        = 8'h00;
	logic [7:0]  reg_b        = 8'h00;
	logic [8:0]  mem_rdata    = 9'h000;
	logic        mem_rbit8    = 1'b0;
	logic [15:0] reg_addr     = 16'h0000;
	logic [7:0]  reg_wdata    = 8'h00;
	logic        reg_wr       = 1'b0;
	logic        reg_rd       = 1'b0;
	logic        instr_ready;
	logic        done;
	logic [1:0]  pc_step;
	logic        illegal;
	logic        mem_rd;
	logic        mem_we;
	logic [15:0] mem_addr;
	logic [8:0]  mem_wdata;
	logic [7:0]  reg_rdata;
	logic [15:0] sp;
	logic [7:0]  program_status_word;
	int          n_fail       = 0;
	int          n_compared   = 0;
	logic [31:0] lfsr_q       = 32'h00010482;
	logic [15:0] sp_m;
	logic [7:0]  psw_m;
	logic [7:0]  opc [8]      = '{8'h64, 8'h65, 8'h63, 8'h66, 8'h60, 8'h80, 8'hFF, 8'h66};

	always #20 ref_clk = ~ref_clk;

	spbpe_exec dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr_opcode(instr_opcode), .instr_lo(instr_lo),
		.instr_hi(instr_hi), .reg_a(reg_a), .reg_b(reg_b), .done(done), .pc_step(pc_step),
		.illegal(illegal), .mem_rd(mem_rd), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rbit8(mem_rbit8),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sp(sp), .program_status_word(program_status_word));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next

	function automatic logic [15:0] src_of(input logic [7:0] op, input logic [7:0] lo,
		input logic [7:0] hi);
		case (op)
			8'h64: return {8'h00, lo};
			8'h65: return {8'h01, lo};
			8'h63: return {8'hFE, lo};
			default: return {hi, lo};
		endcase
	endfunction : src_of

	function automatic logic [1:0] step_of(input logic [7:0] op);
		case (op)
			8'h64, 8'h65, 8'h63: return 2'h2;
			8'h66: return 2'h3;
			8'h60, 8'h80: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction : step_of

	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic roll();
		repeat (9) lfsr_q = lfsr_next(lfsr_q);
	endtask : roll

	task automatic reg_wr_t(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_wr_t

	task automatic reg_rd_t(input logic [15:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_rd_t

	////////////////////////////////////////////////////////////////////////////////
	// one instruction: offer it, log every memory pulse until done
	task automatic run(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
		logic [15:0] ra;
		logic [15:0] wa [2];
		logic [8:0]  wd [2];
		int          nw;
		int          nr;
		logic        fin;
		logic        ill;
		logic [1:0]  st;
		nw  = 0;
		nr  = 0;
		fin = 1'b0;
		ill = 1'b0;
		ra  = 16'h0000;
		st  = step_of(op);
		@(posedge ref_clk);
		instr_valid  <= 1'b1;
		instr_opcode <= op;
		instr_lo     <= lo;
		instr_hi     <= hi;
		@(negedge ref_clk);
		chk("instr_ready idle", instr_ready, 16'h0001);
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		for (int k = 0; k < 12 && !fin; k++) begin
			#1;
			if (mem_rd === 1'b1) begin
				ra = mem_addr;
				nr++;
			end
			if (mem_we === 1'b1) begin
				if (nw < 2) begin
					wa[nw] = mem_addr;
					wd[nw] = mem_wdata;
				end
				nw++;
			end
			if (done === 1'b1) begin
				fin = 1'b1;
				ill = illegal;
			end else begin
				chk("instr_ready busy", instr_ready, 16'h0000);
				@(posedge ref_clk);
			end
		end
		if (!fin) begin
			n_fail++;
			stop_test();
		end
		chk("pc_step", pc_step, st);
		chk("illegal", ill, (st == 2'h0));
		if (st >= 2'h2) begin
			chk("reads", 16'(nr), 16'h0001);
			chk("source addr", ra, src_of(op, lo, hi));
			chk("writes", 16'(nw), 16'h0001);
			chk("push addr", wa[0], sp_m + 16'h0001);
			chk("push data", wd[0], {mem_rbit8 & mem_rdata[8], mem_rdata[7:0]});
			if (mem_rbit8)
				psw_m[1] = mem_rdata[8];
			sp_m = sp_m + 16'h0001;
		end else if (op == 8'h60) begin
			chk("writes", 16'(nw), 16'h0002);
			chk("pair lo addr", wa[0], sp_m + 16'h0001);
			chk("pair hi addr", wa[1], sp_m + 16'h0002);
			chk("pair lo data", wd[0], {psw_m[1], reg_a});
			chk("pair hi data", wd[1], {psw_m[1], reg_b});
			sp_m = sp_m + 16'h0002;
		end else if (op == 8'h80) begin
			chk("writes", 16'(nw), 16'h0001);
			chk("status addr", wa[0], sp_m + 16'h0001);
			chk("status data", wd[0], {psw_m[1], psw_m});
			sp_m = sp_m + 16'h0001;
		end else begin
			chk("writes", 16'(nw), 16'h0000);
		end
		chk("sp", sp, sp_m);
		chk("psw", program_status_word, psw_m);
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		#1 chk("sp reset", sp, 16'h0000);
		chk("psw reset", program_status_word, 16'h0000);
		sp_m = 16'h00C7;
		reg_wr_t(16'hFE0A, 8'hC7);
		reg_wr_t(16'hFE0B, 8'h00);
		reg_rd_t(16'h1234, d);
		chk("unmapped read", d, 16'h0000);
		for (int i = 0; i < 40; i++) begin
			roll();
			psw_m = lfsr_q[7:0];
			reg_wr_t(16'hFE06, psw_m);
			reg_rd_t(16'hFE06, d);
			chk("psw reg", d, psw_m);
			// wrap corner: pair push across the top of the address space
			if (i == 28) begin
				reg_wr_t(16'hFE0A, 8'hFF);
				reg_wr_t(16'hFE0B, 8'hFF);
				sp_m = 16'hFFFF;
			end
			mem_rdata <= lfsr_q[16:8];
			mem_rbit8 <= lfsr_q[17];
			reg_a     <= lfsr_q[25:18];
			reg_b     <= lfsr_q[31:24];
			roll();
			run(opc[i % 8], lfsr_q[7:0], lfsr_q[15:8]);
			reg_rd_t(16'hFE0A, d);
			chk("sp low reg", d, sp_m[7:0]);
			reg_rd_t(16'hFE0B, d);
			chk("sp high reg", d, sp_m[15:8]);
		end
		// mid-run reset must clear the pointer and status word again
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		#1 chk("sp reset again", sp, 16'h0000);
		chk("psw reset again", program_status_word, 16'h0000);
		stop_test();
	end
endmodule : tb_spbpe_exec
